// >>> common/jid_pkg.sv
/*
  jid_pkg: constants shared by the jack insertion detect block.
  Assumes a 100 MHz system clock and a 16-bit plain register port.
*/
`default_nettype none

package jid_pkg;

  // register word offsets, as seen on the register port
  localparam logic [15:0] JID_ADDR_ENA   = 16'h02d3;
  localparam logic [15:0] JID_ADDR_STS_A = 16'h1886;
  localparam logic [15:0] JID_ADDR_STS_B = 16'h1986;
  localparam logic [15:0] JID_ADDR_DB    = 16'h1a06;
  localparam logic [15:0] JID_ADDR_MASK  = 16'h1a08;

  // number of jack-sense inputs
  localparam int unsigned JID_NUM_IN = 3;

  // field positions, index 0 is input one
  localparam int unsigned JID_ENA_POS [3] = '{0, 1, 2};
  localparam int unsigned JID_SLOT_POS[3] = '{0, 2, 8};
  localparam int unsigned JID_RMSK_POS[3] = '{0, 1, 2};
  localparam int unsigned JID_FMSK_POS[3] = '{8, 9, 10};

  // values after reset
  localparam logic [2:0]  JID_ENA_RST  = 3'h0;
  localparam logic [2:0]  JID_DB_RST   = 3'h0;
  localparam logic [2:0]  JID_MASK_RST = 3'h7;
  localparam logic [2:0]  JID_SYNC_RST = 3'h7;  // pins idle high
  localparam logic [15:0] JID_RD_RST   = 16'h0000;

  // slow debounce tick derived from the system clock
  localparam int unsigned JID_CLK_HZ   = 100_000_000;
  localparam int unsigned JID_SLOW_HZ  = 32_000;
  localparam int unsigned JID_TICK_CYC = JID_CLK_HZ / JID_SLOW_HZ;
  localparam int unsigned JID_TICK_W   = 12;

  // stable slow ticks needed before a debounced level changes
  localparam int unsigned JID_DB_TICKS_DEF = 4;
  localparam int unsigned JID_DB_CNT_W     = 4;

endpackage : jid_pkg

`default_nettype wire

// >>> hw/jid_debounce.sv
/*
  jid_debounce: debounce filter for one synchronized jack-sense level.
  Assumes level_in is already synchronized and tick_in is a one-cycle
  pulse from the slow tick generator in the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module jid_debounce
  import jid_pkg::*;
#(
  parameter int unsigned TICKS = JID_DB_TICKS_DEF
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic srst_in,
  // level, slow tick and filter switch
  input  wire logic level_in,
  input  wire logic tick_in,
  input  wire logic filt_on_in,
  // filtered level
  output logic      level_out
);

  localparam logic [JID_DB_CNT_W-1:0] CNT_LAST =
    JID_DB_CNT_W'(TICKS - 1);

  typedef struct packed {
    logic [JID_DB_CNT_W-1:0] cnt;
    logic                    stable;
  } jid_db_state_t;

  jid_db_state_t q, d;

  // counter is 4 bits wide, so longer filters are refused
  if (TICKS < 1 || TICKS > 15) begin : g_bad_ticks
    $error("jid_debounce: TICKS must lie in 1..15");
  end

  // a level must hold for TICKS slow ticks before it is taken
  always_comb begin : p_next
    d = q;
    if (!filt_on_in) begin
      d.stable = level_in;
      d.cnt    = '0;
    end else if (level_in == q.stable) begin
      d.cnt = '0;  // bounce restarts the wait
    end else if (tick_in) begin
      if (q.cnt == CNT_LAST) begin
        d.stable = level_in;
        d.cnt    = '0;
      end else begin
        d.cnt = q.cnt + JID_DB_CNT_W'(1);
      end
    end
  end

  // state register, level starts as no jack
  always_ff @(posedge clk_in) begin : p_reg
    if (srst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level_out = q.stable;

endmodule : jid_debounce

`default_nettype wire

// >>> hw/jid_top.sv
/*
  jid_top: jack insertion detect for three switch-sense pins.
  Holds pin synchronizers, a slow debounce tick, one debounce filter
  per input, the register file and the edge event outputs.
  Assumes pins are asynchronous, pulled low by an inserted jack, and
  that sleep_mode_in and slow_clk_on_in come from logic on clk_in.
  Events are one-cycle pulses with no sticky flag behind them: the
  interrupt collector outside this block must latch them itself.
  The slow tick is counted down from clk_in, so its period is only
  as exact as the ratio of the two clock rates.
*/
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module jid_top
  import jid_pkg::*;
#(
  parameter int unsigned DB_TICKS = JID_DB_TICKS_DEF
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  // register port
  input  wire logic [15:0] reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [15:0] reg_rdata_out,
  // jack switch pins, low while a jack is in
  input  wire logic [2:0]  jack_sense_pin_in,
  // power state from the system controller
  input  wire logic        sleep_mode_in,
  input  wire logic        slow_clk_on_in,
  // detect levels towards the mic sense clamp logic
  output logic      [2:0]  jack_present_signal_out,
  // one-cycle edge events, one bit per input
  output logic      [2:0]  jack_rise_event_out,
  output logic      [2:0]  jack_fall_event_out
);

  localparam logic [JID_TICK_W-1:0] TICK_LAST =
    JID_TICK_W'(JID_TICK_CYC - 1);

  typedef struct packed {
    // pin synchronizer, raw pin polarity
    logic [2:0]            sync1;
    logic [2:0]            sync2;
    // filtered level and enable-gated detect
    logic [2:0]            lvl;
    logic [2:0]            jd;
    // software controls
    logic [2:0]            ena;
    logic [2:0]            db;
    logic [2:0]            rmask;
    logic [2:0]            fmask;
    // event pulses
    logic [2:0]            rise_ev;
    logic [2:0]            fall_ev;
    // slow tick divider
    logic [JID_TICK_W-1:0] tick_cnt;
    logic                  tick;
    // registered read answer
    logic [15:0]           rdata;
  } jid_state_t;

  jid_state_t q, d;

  logic [2:0] filt_on;
  logic [2:0] filt_lvl;
  logic [2:0] sense_lvl;  // synchronized, 1 = jack in
  logic [2:0] rise_now;   // qualified insertion edges
  logic [2:0] fall_now;   // qualified removal edges

  // refuse a divider that does not fit its counter
  if (JID_TICK_CYC < 1 || JID_TICK_CYC > (1 << JID_TICK_W))
  begin : g_bad_tick
    $error("jid_top: slow tick divider does not fit its counter");
  end

  // debounce filter is 4 bits deep
  if (DB_TICKS < 1 || DB_TICKS > 15) begin : g_bad_db
    $error("jid_top: DB_TICKS must lie in 1..15");
  end

  // ports are three bits wide, so the package must agree
  if (JID_NUM_IN != 3) begin : g_bad_num
    $error("jid_top: JID_NUM_IN must be 3");
  end

  // every field position must land inside the 16-bit word
  for (genvar c = 0; c < JID_NUM_IN; c++) begin : g_chk_pos
    if (JID_ENA_POS[c] > 15 || JID_SLOT_POS[c] > 15) begin : g_bad_pos
      $error("jid_top: enable or status bit outside the word");
    end
    if (JID_RMSK_POS[c] > 15 || JID_FMSK_POS[c] > 15) begin : g_bad_msk
      $error("jid_top: mask bit outside the word");
    end
    // a shared bit would tie the two edge masks together
    if (JID_RMSK_POS[c] == JID_FMSK_POS[c]) begin : g_msk_clash
      $error("jid_top: rising and falling masks share a bit");
    end
  end

  // two inputs on one status or enable bit would hide each other
  if (JID_SLOT_POS[0] == JID_SLOT_POS[1] ||
      JID_SLOT_POS[0] == JID_SLOT_POS[2] ||
      JID_SLOT_POS[1] == JID_SLOT_POS[2]) begin : g_slot_clash
    $error("jid_top: two inputs share a status bit");
  end

  if (JID_ENA_POS[0] == JID_ENA_POS[1] ||
      JID_ENA_POS[0] == JID_ENA_POS[2] ||
      JID_ENA_POS[1] == JID_ENA_POS[2]) begin : g_ena_clash
    $error("jid_top: two inputs share an enable bit");
  end

  // spread a 3-bit field onto the slot positions 0, 2 and 8
  function automatic logic [15:0] jid_pack_slot(
    input logic [2:0] v
  );
    logic [15:0] w;
    w = '0;
    for (int i = 0; i < JID_NUM_IN; i++) begin
      w[JID_SLOT_POS[i]] = v[i];
    end
    return w;
  endfunction : jid_pack_slot

  // gather the slot positions 0, 2 and 8 into a 3-bit field
  function automatic logic [2:0] jid_unpack_slot(
    input logic [15:0] w
  );
    logic [2:0] v;
    v = '0;
    for (int i = 0; i < JID_NUM_IN; i++) begin
      v[i] = w[JID_SLOT_POS[i]];
    end
    return v;
  endfunction : jid_unpack_slot

  // enable bits sit at 0, 1 and 2
  function automatic logic [15:0] jid_pack_ena(
    input logic [2:0] v
  );
    logic [15:0] w;
    w = '0;
    for (int i = 0; i < JID_NUM_IN; i++) begin
      w[JID_ENA_POS[i]] = v[i];
    end
    return w;
  endfunction : jid_pack_ena

  // gather the enable bits back into a 3-bit field
  function automatic logic [2:0] jid_unpack_ena(
    input logic [15:0] w
  );
    logic [2:0] v;
    v = '0;
    for (int i = 0; i < JID_NUM_IN; i++) begin
      v[i] = w[JID_ENA_POS[i]];
    end
    return v;
  endfunction : jid_unpack_ena

  // mask word: rising masks low, falling masks from bit 8
  function automatic logic [15:0] jid_pack_mask(
    input logic [2:0] r,
    input logic [2:0] f
  );
    logic [15:0] w;
    w = '0;
    for (int i = 0; i < JID_NUM_IN; i++) begin
      w[JID_RMSK_POS[i]] = r[i];
      w[JID_FMSK_POS[i]] = f[i];
    end
    return w;
  endfunction : jid_pack_mask

  // gather the rising-edge masks
  function automatic logic [2:0] jid_unpack_rmask(
    input logic [15:0] w
  );
    logic [2:0] v;
    v = '0;
    for (int i = 0; i < JID_NUM_IN; i++) begin
      v[i] = w[JID_RMSK_POS[i]];
    end
    return v;
  endfunction : jid_unpack_rmask

  // gather the falling-edge masks
  function automatic logic [2:0] jid_unpack_fmask(
    input logic [15:0] w
  );
    logic [2:0] v;
    v = '0;
    for (int i = 0; i < JID_NUM_IN; i++) begin
      v[i] = w[JID_FMSK_POS[i]];
    end
    return v;
  endfunction : jid_unpack_fmask

  // inversion sits behind the second stage, so nothing but the
  // synchronizer ever sees the raw asynchronous pin
  assign sense_lvl = ~q.sync2;

  // filter only outside sleep; in sleep the raw level goes through
  assign filt_on = q.db & {3{~sleep_mode_in}};

  // a rise needs the level to go up while enabled; the old detect
  // was then 0 whatever the old enable was
  assign rise_now = q.ena & filt_lvl & ~q.lvl;
  // a fall needs a detect that really was 1 and is still enabled, so
  // enabling an input in the cycle its level drops stays silent
  assign fall_now = q.jd & q.ena & ~filt_lvl;

  // one filter per input, fed by the second synchronizer stage
  for (genvar g = 0; g < JID_NUM_IN; g++) begin : g_filt
    jid_debounce #(
      .TICKS      (DB_TICKS)
    ) u_db (
      .clk_in     (clk_in),
      .srst_in    (srst_in),
      .level_in   (sense_lvl[g]),
      .tick_in    (q.tick),
      .filt_on_in (filt_on[g]),
      .level_out  (filt_lvl[g])
    );
  end

  // next state: sync, tick, detect, events, then register port
  always_comb begin : p_next
    d = q;

    // two stages on the raw pin before anything else reads it
    d.sync1 = jack_sense_pin_in;
    d.sync2 = q.sync1;

    // slow tick stops with the 32 kHz source, freezing any filter that is on;
    // the count restarts from zero, so the first tick after the
    // source returns comes a full slow period later
    if (!slow_clk_on_in) begin
      d.tick_cnt = '0;
      d.tick     = 1'b0;
    end else if (q.tick_cnt == TICK_LAST) begin
      d.tick_cnt = '0;
      d.tick     = 1'b1;
    end else begin
      d.tick_cnt = q.tick_cnt + JID_TICK_W'(1);
      d.tick     = 1'b0;
    end

    // level is tracked even while off, so enabling gives no edge;
    // the detect output is gated by the enable, the level is not
    d.lvl = filt_lvl;
    d.jd  = q.ena & filt_lvl;

    // sleep does not gate events, they serve as wake-up
    d.rise_ev = rise_now & ~q.rmask;
    d.fall_ev = fall_now & ~q.fmask;

    // register writes; status words ignore writes, and a write lands
    // at the strobe's edge so the next cycle already uses it
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        JID_ADDR_ENA: begin
          d.ena = jid_unpack_ena(reg_wdata_in);
        end
        JID_ADDR_DB: begin
          d.db = jid_unpack_slot(reg_wdata_in);
        end
        JID_ADDR_MASK: begin
          d.rmask = jid_unpack_rmask(reg_wdata_in);
          d.fmask = jid_unpack_fmask(reg_wdata_in);
        end
        default: begin
          d.ena = q.ena;  // unmapped write has no effect
        end
      endcase
    end

    // read data stand one cycle after the strobe, else zero; both
    // status copies come from one register so they never differ
    d.rdata = JID_RD_RST;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        JID_ADDR_ENA: begin
          d.rdata = jid_pack_ena(q.ena);
        end
        JID_ADDR_STS_A, JID_ADDR_STS_B: begin
          d.rdata = jid_pack_slot(q.jd);
        end
        JID_ADDR_DB: begin
          d.rdata = jid_pack_slot(q.db);
        end
        JID_ADDR_MASK: begin
          d.rdata = jid_pack_mask(q.rmask, q.fmask);
        end
        default: begin
          d.rdata = JID_RD_RST;  // unmapped reads as zero
        end
      endcase
    end
  end

  // state register with defined reset values; masks reset to 1 so
  // no event leaves the block until software has unmasked it
  always_ff @(posedge clk_in) begin : p_reg
    if (srst_in) begin
      q          <= '0;
      q.sync1    <= JID_SYNC_RST;  // pins idle high, no false edge
      q.sync2    <= JID_SYNC_RST;
      q.ena      <= JID_ENA_RST;
      q.db       <= JID_DB_RST;
      q.rmask    <= JID_MASK_RST;
      q.fmask    <= JID_MASK_RST;
      q.rdata    <= JID_RD_RST;
    end else begin
      q <= d;
    end
  end

  // every output comes straight from the state register, so the
  // event pulses are glitch free for an asynchronous wake-up path
  assign reg_rdata_out           = q.rdata;
  assign jack_present_signal_out = q.jd;
  assign jack_rise_event_out     = q.rise_ev;
  assign jack_fall_event_out     = q.fall_ev;

endmodule : jid_top

`default_nettype wire

// >>> bench/jid_top_assertions.sv
/*
  jid_top_checker: port-level properties of the jack detect block.
  Assumes one clock domain and the register map of jid_pkg.
*/
`timescale 1ns/1ps
`default_nettype none

module jid_top_checker
  import jid_pkg::*;
#(
  parameter int unsigned DB_TICKS = JID_DB_TICKS_DEF
) (
  input wire logic        clk_in,
  input wire logic        srst_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic [2:0]  jack_sense_pin_in,
  input wire logic        sleep_mode_in,
  input wire logic [2:0]  jack_present_signal_out,
  input wire logic [2:0]  jack_rise_event_out,
  input wire logic [2:0]  jack_fall_event_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  // status word layout and written enables, for $past
  logic [15:0] sts_w;
  logic [2:0]  wena;
  logic [2:0]  jp;
  assign jp = jack_present_signal_out;
  assign sts_w = {7'h0, jp[2], 5'h0, jp[1], 1'b0, jp[0]};
  assign wena = reg_wdata_in[2:0];

  sequence rd_at(logic [15:0] a);
    reg_rd_in && reg_addr_in == a;
  endsequence
  sequence ena_wr;
    reg_wr_in && reg_addr_in == JID_ADDR_ENA;
  endsequence
  // filter bypass needs the sync stages refilled first
  sequence asleep;
    sleep_mode_in [*4];
  endsequence

  rdata_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0)
    else $error("read data not idle");
  sts_a_a: assert property (rd_at(JID_ADDR_STS_A) |=> reg_rdata_out == $past(sts_w))
    else $error("status copy a wrong");
  sts_b_a: assert property (rd_at(JID_ADDR_STS_B) |=> reg_rdata_out == $past(sts_w))
    else $error("status copy b wrong");
  rise_cause_a: assert property ((jack_rise_event_out & ~(jp & ~$past(jp))) == 3'h0)
    else $error("rise event without rise");
  fall_cause_a: assert property ((jack_fall_event_out & ~(~jp & $past(jp))) == 3'h0)
    else $error("fall event without fall");
  edge_excl_a: assert property ((jack_rise_event_out & jack_fall_event_out) == 3'h0)
    else $error("both edges at once");
  sleep_bypass_a: assert property (asleep |-> (jp & $past(jack_sense_pin_in, 3)) == 3'h0)
    else $error("present with open contact in sleep");
  ena_gate_a: assert property (ena_wr |=> (jp & ~$past(wena)) == 3'h0)
    else $error("disabled input detects");
endmodule : jid_top_checker

bind jid_top jid_top_checker #(.DB_TICKS(DB_TICKS)) i_jid_top_checker (
  .clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .jack_sense_pin_in(jack_sense_pin_in), .sleep_mode_in(sleep_mode_in),
  .jack_present_signal_out(jack_present_signal_out),
  .jack_rise_event_out(jack_rise_event_out),
  .jack_fall_event_out(jack_fall_event_out));

`default_nettype wire

// >>> bench/jid_jack_socket.sv
/*
  jid_jack_socket: jack sockets with one switch contact per input.
  Assumes pull-ups on the sense pins, so an open contact reads high.
*/
`timescale 1ns/1ps
`default_nettype none

module jid_jack_socket (
  // pacing clock
  input  wire logic       clk_in,
  // plug state and bounce request
  input  wire logic [2:0] insert_in,
  input  wire logic       chatter_in,
  // contacts towards the sense pins
  output logic      [2:0] pin_out
);
  logic [2:0] last_q;
  logic [2:0] chg_q;
  logic [3:0] cnt_q;

  initial begin
    last_q = 3'h0;
    chg_q = 3'h0;
    cnt_q = 4'h0;
    pin_out = 3'h7;
  end

  // a moving contact bounces 14 cycles, unlike an ideal switch
  always @(posedge clk_in) begin
    last_q <= insert_in;
    if (chatter_in && insert_in != last_q) begin
      chg_q <= insert_in ^ last_q;
      cnt_q <= 4'hf;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
    pin_out <= ~insert_in ^ ((cnt_q > 4'h1) ? (chg_q & 3'($urandom)) : 3'h0);
  end
endmodule : jid_jack_socket

`default_nettype wire

// >>> bench/jack_insertion_detect_tb.sv
/*
  jack_insertion_detect_tb: self-checking bench for jid_top.
  Assumes the socket model and the bound checker beside it.
*/
`timescale 1ns/1ps
`default_nettype none

module jack_insertion_detect_tb
  import jid_pkg::*;
;
  logic        clk_in, srst_in, reg_wr_in, reg_rd_in, sleep_mode_in;
  logic        slow_clk_on_in, chatter, rd_pend;
  logic [15:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
  logic [15:0] exp_q[$];
  logic [2:0]  pin, insert, present, rise_ev, fall_ev, p, prev;
  int          errors, n_checks, k, rc[3], fc[3], rb[3], fb[3];

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // short debounce keeps the run brief
  jid_top #(.DB_TICKS(2)) i_jid_top (
    .clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .jack_sense_pin_in(pin), .sleep_mode_in(sleep_mode_in),
    .slow_clk_on_in(slow_clk_on_in), .jack_present_signal_out(present),
    .jack_rise_event_out(rise_ev), .jack_fall_event_out(fall_ev));
  jid_jack_socket i_jid_jack_socket (.clk_in(clk_in), .insert_in(insert),
    .chatter_in(chatter), .pin_out(pin));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    reg_rd_in <= 1'b0;
    @(posedge clk_in);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    reg_wr_in <= 1'b0;
    exp_q.push_back(e);
    @(posedge clk_in);
  endtask : rd

  task automatic idle(input int n);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    repeat (n) @(posedge clk_in);
  endtask : idle

  task automatic settle(input logic [2:0] e);
    idle(12);
    check({13'h0, present}, {13'h0, e});
  endtask : settle

  task automatic chk_ev(input logic [2:0] r, input logic [2:0] f);
    for (int i = 0; i < 3; i++) begin
      check(16'(rc[i] - rb[i]), {15'h0, r[i]});
      check(16'(fc[i] - fb[i]), {15'h0, f[i]});
      rb[i] = rc[i];
      fb[i] = fc[i];
    end
  endtask : chk_ev

  task automatic wait_present(input logic [2:0] e, input int lim);
    for (k = 0; k < lim && present !== e; k++) @(posedge clk_in);
    if (k == lim) begin
      errors++;
      finish_test();
    end
  endtask : wait_present

  function automatic logic [15:0] sts(input logic [2:0] v);
    return {7'h0, v[2], 5'h0, v[1], 1'b0, v[0]};
  endfunction : sts

  // oldest read note against each answer; events counted per input
  always @(posedge clk_in) begin
    if (rd_pend) check(reg_rdata_out, exp_q.pop_front());
    rd_pend <= reg_rd_in;
    for (int i = 0; i < 3; i++) begin
      rc[i] <= rc[i] + int'(rise_ev[i]);
      fc[i] <= fc[i] + int'(fall_ev[i]);
    end
  end

  initial begin
    srst_in = 1'b1;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 16'h0;
    reg_wdata_in = 16'h0;
    sleep_mode_in = 1'b0;
    slow_clk_on_in = 1'b1;
    chatter = 1'b0;
    rd_pend = 1'b0;
    insert = 3'h0;
    void'($urandom(32'h36053374));
    repeat (3) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    // reset values, read-only and unmapped places
    rd(JID_ADDR_ENA, 16'h0);
    rd(JID_ADDR_DB, 16'h0);
    rd(JID_ADDR_MASK, 16'h0707);
    rd(JID_ADDR_STS_A, 16'h0);
    rd(16'h0000, 16'h0);
    wr(JID_ADDR_STS_B, 16'hffff);
    rd(JID_ADDR_STS_B, 16'h0);
    wr(JID_ADDR_ENA, 16'h0007);
    rd(JID_ADDR_ENA, 16'h0007);
    wr(JID_ADDR_MASK, 16'h0);
    // random plug patterns, every edge unmasked
    prev = 3'h0;
    repeat (6) begin
      p = 3'($urandom);
      insert <= p;
      settle(p);
      rd(JID_ADDR_STS_A, sts(p));
      rd(JID_ADDR_STS_B, sts(p));
      idle(2);
      chk_ev(p & ~prev, prev & ~p);
      prev = p;
    end
    insert <= 3'h0;
    settle(3'h0);
    chk_ev(3'h0, prev);
    // every mix of rising and falling masks, all three inputs alike
    for (int m = 0; m < 4; m++) begin
      wr(JID_ADDR_MASK, {5'h0, {3{m[1]}}, 5'h0, {3{m[0]}}});
      rd(JID_ADDR_MASK, {5'h0, {3{m[1]}}, 5'h0, {3{m[0]}}});
      insert <= 3'h7;
      settle(3'h7);
      chk_ev(m[0] ? 3'h0 : 3'h7, 3'h0);
      insert <= 3'h0;
      settle(3'h0);
      chk_ev(3'h0, m[1] ? 3'h0 : 3'h7);
    end
    wr(JID_ADDR_MASK, 16'h0);
    // disabled input stays silent; enabling later gives no event
    wr(JID_ADDR_ENA, 16'h0002);
    insert <= 3'h7;
    settle(3'h2);
    wr(JID_ADDR_ENA, 16'h0007);
    settle(3'h7);
    chk_ev(3'h2, 3'h0);
    insert <= 3'h0;
    settle(3'h0);
    chk_ev(3'h0, 3'h7);
    // bouncing contact under debounce, slow clock stopped first
    wr(JID_ADDR_DB, 16'h0105);
    rd(JID_ADDR_DB, 16'h0105);
    slow_clk_on_in <= 1'b0;
    chatter <= 1'b1;
    insert <= 3'h1;
    idle(7000);
    check({13'h0, present}, 16'h0);
    slow_clk_on_in <= 1'b1;
    wait_present(3'h1, 9500);
    insert <= 3'h0;
    wait_present(3'h0, 9500);
    idle(2);
    chk_ev(3'h1, 3'h1);
    // sleep skips the filter but still raises events
    chatter <= 1'b0;
    sleep_mode_in <= 1'b1;
    insert <= 3'h4;
    settle(3'h4);
    chk_ev(3'h4, 3'h0);
    finish_test();
  end
endmodule : jack_insertion_detect_tb

`default_nettype wire
